// [hdl/serial_io_expansion.sv]
// Serial I/O expansion path: interface board plus one or two I/O boards.
//
// Functional notes
// - States travel only as serial bus bits.
// - Bus address picks one of 63 inputs.
// - Second board returns on its own line.
// - Interface forwards the selected return line.
// - Serial writes build 32 parallel outputs per board.
// - Overloaded output off only during overload.
// - Overload reported at input position 63.
// - Variant: 26 unipolar, 5 bipolar, stop output.
`timescale 1ns/100ps
`default_nettype none
module serial_io_expansion
    import io_expansion_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Bit-serial bus from the processor.
    input  wire bus_req_t    bus_req,
    output logic             serial_in_ff,
    // Board straps.
    input  wire logic        board_two_present,
    input  wire logic        bipolar_variant,
    // Programmable input points of each board.
    input  wire logic [62:0] board_one_inputs,
    input  wire logic [62:0] board_two_inputs,
    // Overcurrent sense of each board, channel 31 is the emergency-stop output.
    input  wire logic [31:0] board_one_overcurrent,
    input  wire logic [31:0] board_two_overcurrent,
    // Machine outputs.
    output logic [31:0]      board_one_out_ff,
    output logic [31:0]      board_two_out_ff,
    output logic [4:0]       board_one_neg_ff,
    output logic [4:0]       board_two_neg_ff
);

    // Picks one bit of a 64-bit return vector by point index.
    function automatic logic point_sel(input logic [63:0] vec, input logic [5:0] idx);
        point_sel = vec[idx];
    endfunction

    // Two-stage synchronisers for every pin-side input.
    bus_req_t    req_s1_ff;
    bus_req_t    req_s2_ff;
    logic        strobe_d_ff;
    logic [1:0]  strap_s1_ff;
    logic [1:0]  strap_s2_ff;
    logic [62:0] in1_s1_ff;
    logic [62:0] in1_s2_ff;
    logic [62:0] in2_s1_ff;
    logic [62:0] in2_s2_ff;
    logic [31:0] ovl1_s1_ff;
    logic [31:0] ovl1_s2_ff;
    logic [31:0] ovl2_s1_ff;
    logic [31:0] ovl2_s2_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_s1_ff   <= '0;
            req_s2_ff   <= '0;
            strobe_d_ff <= 1'h0;
            strap_s1_ff <= 2'h0;
            strap_s2_ff <= 2'h0;
            in1_s1_ff   <= '0;
            in1_s2_ff   <= '0;
            in2_s1_ff   <= '0;
            in2_s2_ff   <= '0;
            ovl1_s1_ff  <= CHAN_RESET;
            ovl1_s2_ff  <= CHAN_RESET;
            ovl2_s1_ff  <= CHAN_RESET;
            ovl2_s2_ff  <= CHAN_RESET;
        end else begin
            req_s1_ff   <= bus_req;
            req_s2_ff   <= req_s1_ff;
            strobe_d_ff <= req_s2_ff.strobe;
            strap_s1_ff <= {bipolar_variant, board_two_present};
            strap_s2_ff <= strap_s1_ff;
            in1_s1_ff   <= board_one_inputs;
            in1_s2_ff   <= in1_s1_ff;
            in2_s1_ff   <= board_two_inputs;
            in2_s2_ff   <= in2_s1_ff;
            ovl1_s1_ff  <= board_one_overcurrent;
            ovl1_s2_ff  <= ovl1_s1_ff;
            ovl2_s1_ff  <= board_two_overcurrent;
            ovl2_s2_ff  <= ovl2_s1_ff;
        end
    end

    logic        two_present;
    logic        bipolar_on;
    logic        wr_edge;
    logic        ovl_flag1;
    logic        ovl_flag2;
    logic [63:0] ret1;
    logic [63:0] ret2;

    // Each board returns its points with the overload flag in the top position.
    assign two_present = strap_s2_ff[0];
    assign bipolar_on  = strap_s2_ff[1];
    assign wr_edge     = req_s2_ff.strobe & ~strobe_d_ff;
    assign ovl_flag1   = |ovl1_s2_ff;
    assign ovl_flag2   = |ovl2_s2_ff;
    assign ret1        = {ovl_flag1, in1_s2_ff};
    assign ret2        = {ovl_flag2, in2_s2_ff};

    // The interface board forwards the return line of the addressed board, or of board one when board two is absent.
    logic nxt_serial_in;
    always_comb begin
        if (two_present && req_s2_ff.board == BOARD_TWO) begin
            nxt_serial_in = point_sel(ret2, req_s2_ff.point);
        end else begin
            nxt_serial_in = point_sel(ret1, req_s2_ff.point);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serial_in_ff <= OUT_RESET;
        end else begin
            serial_in_ff <= nxt_serial_in;
        end
    end

    // Serial-to-parallel conversion: each rising strobe edge to points 0 to 31 stores one output bit.
    logic [NUM_BOARDS-1:0][31:0] pos;
    logic [NUM_BOARDS-1:0][31:0] neg;
    logic [NUM_BOARDS-1:0][31:0] ovl;
    assign ovl[0] = ovl1_s2_ff;
    assign ovl[1] = ovl2_s2_ff;

    for (genvar b = 0; b < NUM_BOARDS; b++) begin : g_board
        for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
            localparam logic IS_BIP = (c >= BIPOLAR_LO) && (c <= BIPOLAR_HI);
            out_channel u_chan (
                .clk        (clk),
                .rstn       (rstn),
                .write_en   (wr_edge && req_s2_ff.board == 1'(b)
                             && req_s2_ff.point == 6'(c)),
                .write_data (req_s2_ff.data),
                .overload   (ovl[b][c]),
                .bipolar    (bipolar_on & IS_BIP),
                .pos_ff     (pos[b][c]),
                .neg_ff     (neg[b][c])
            );
        end
    end

    assign board_one_out_ff = pos[0];
    assign board_two_out_ff = pos[1];
    assign board_one_neg_ff = neg[0][BIPOLAR_HI:BIPOLAR_LO];
    assign board_two_neg_ff = neg[1][BIPOLAR_HI:BIPOLAR_LO];

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);

    a_read_board_one: assert property (
        (req_s2_ff.board == BOARD_ONE && req_s2_ff.point != OVERLOAD_POINT)
        |=> serial_in_ff == $past(in1_s2_ff[req_s2_ff.point[5:0]]))
        else $error("board one input point not returned");

    a_read_board_two: assert property (
        (two_present && req_s2_ff.board == BOARD_TWO
         && req_s2_ff.point != OVERLOAD_POINT)
        |=> serial_in_ff == $past(in2_s2_ff[req_s2_ff.point[5:0]]))
        else $error("board two input point not returned");

    a_absent_board_two: assert property (
        (!two_present && req_s2_ff.board == BOARD_TWO)
        |=> serial_in_ff == $past(ret1[req_s2_ff.point]))
        else $error("absent board two was read");

    a_overload_flag_one: assert property (
        (req_s2_ff.board == BOARD_ONE && req_s2_ff.point == OVERLOAD_POINT)
        |=> serial_in_ff == $past(|ovl1_s2_ff))
        else $error("board one overload flag wrong");

    a_overload_flag_two: assert property (
        (two_present && req_s2_ff.board == BOARD_TWO
         && req_s2_ff.point == OVERLOAD_POINT)
        |=> serial_in_ff == $past(|ovl2_s2_ff))
        else $error("board two overload flag wrong");

    a_write_output: assert property (
        (wr_edge && req_s2_ff.board == BOARD_ONE && req_s2_ff.point <= ESTOP_POINT)
        |=> board_one_out_ff[$past(req_s2_ff.point[4:0])]
            == ($past(req_s2_ff.data) & ~$past(ovl1_s2_ff[req_s2_ff.point[4:0]])))
        else $error("written output bit not driven");

    a_overload_off: assert property (
        1'b1 |=> ((board_one_out_ff & $past(ovl1_s2_ff)) == CHAN_RESET
                  && (board_two_out_ff & $past(ovl2_s2_ff)) == CHAN_RESET))
        else $error("output driven during overload");

    a_bipolar_exclusive: assert property (
        1'b1 |=> ((board_one_neg_ff & board_one_out_ff[BIPOLAR_HI:BIPOLAR_LO]) == 5'h00
                  && ($past(bipolar_on) || board_one_neg_ff == 5'h00)))
        else $error("bipolar output both polarities or on unipolar variant");

    // Board two mirrors the board one output checks.
    a_write_board_two: assert property (
        (wr_edge && req_s2_ff.board == BOARD_TWO && req_s2_ff.point <= ESTOP_POINT)
        |=> board_two_out_ff[$past(req_s2_ff.point[4:0])]
            == ($past(req_s2_ff.data) & ~$past(ovl2_s2_ff[req_s2_ff.point[4:0]])))
        else $error("written board two output bit not driven");

    a_bipolar_two: assert property (
        1'b1 |=> ((board_two_neg_ff & board_two_out_ff[BIPOLAR_HI:BIPOLAR_LO]) == 5'h00
                  && ($past(bipolar_on) || board_two_neg_ff == 5'h00)))
        else $error("board two bipolar output both polarities or on unipolar variant");

    // The negative side of a bipolar channel is switched off by its overload too.
    a_overload_neg_off: assert property (
        1'b1 |=> ((board_one_neg_ff & $past(ovl1_s2_ff[BIPOLAR_HI:BIPOLAR_LO])) == 5'h00
                  && (board_two_neg_ff & $past(ovl2_s2_ff[BIPOLAR_HI:BIPOLAR_LO])) == 5'h00))
        else $error("negative output driven during overload");

endmodule
`default_nettype wire

// [hdl/io_expansion_pkg.sv]
// Constants and carrier types shared by the serial I/O expansion path.
package io_expansion_pkg;

    // Bus address layout: one board-select bit above a six-bit point index.
    localparam int       POINT_W        = 6;
    localparam int       NUM_INPUTS     = 63;
    localparam int       NUM_CHAN       = 32;
    localparam int       NUM_BOARDS     = 2;
    localparam logic     BOARD_ONE      = 1'h0;
    localparam logic     BOARD_TWO      = 1'h1;
    localparam logic [5:0] OVERLOAD_POINT = 6'h3F;
    localparam logic [5:0] ESTOP_POINT    = 6'h1F;

    // Output channels 26 to 30 become bipolar on the alternative board variant.
    localparam int       BIPOLAR_LO     = 26;
    localparam int       BIPOLAR_HI     = 30;

    // Reset values.
    localparam logic       OUT_RESET    = 1'h0;
    localparam logic [31:0] CHAN_RESET  = 32'h0000_0000;

    // One bit-serial bus request as presented by the processor.
    typedef struct packed {
        logic       board;
        logic [5:0] point;
        logic       data;
        logic       strobe;
    } bus_req_t;

endpackage

// [hdl/out_channel.sv]
// One supervised machine output channel with its latched serial bit.
`timescale 1ns/100ps
`default_nettype none
module out_channel
    import io_expansion_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rstn,
    // Serial write of this channel's bit.
    input  wire logic write_en,
    input  wire logic write_data,
    // Synchronised overcurrent sense and variant strap.
    input  wire logic overload,
    input  wire logic bipolar,
    // Driven output stage.
    output logic      pos_ff,
    output logic      neg_ff
);

    logic latch_ff;
    logic nxt_latch;
    logic nxt_pos;
    logic nxt_neg;

    // The stored bit survives an overload so the output resumes afterwards.
    always_comb begin
        nxt_latch = write_en ? write_data : latch_ff;
        nxt_pos   = nxt_latch & ~overload;
        nxt_neg   = bipolar & ~nxt_latch & ~overload;
    end

    // Channel registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latch_ff <= OUT_RESET;
            pos_ff   <= OUT_RESET;
            neg_ff   <= OUT_RESET;
        end else begin
            latch_ff <= nxt_latch;
            pos_ff   <= nxt_pos;
            neg_ff   <= nxt_neg;
        end
    end

endmodule
`default_nettype wire

// [sim/cpu_model.sv]
// Processor model that drives the bit-serial bus of the expansion path.
`timescale 1ns/100ps
`default_nettype none
module cpu_model
    import io_expansion_pkg::*;
(
    // Clock.
    input  wire logic     clk,
    // Bit-serial bus toward the expansion path.
    output var bus_req_t  bus_req,
    input  wire logic     serial_in_ff
);
    // The bus idles with the strobe low from time zero.
    initial begin
        bus_req = '0;
    end

    // One serial write: address first, strobe high three cycles, low three cycles.
    task automatic write_bit(input logic brd, input logic [5:0] pt, input logic d);
        @(posedge clk);
        #1;
        bus_req.board = brd;
        bus_req.point = pt;
        bus_req.data = d;
        @(posedge clk);
        #1;
        bus_req.strobe = 1'h1;
        repeat (3) @(posedge clk);
        #1;
        bus_req.strobe = 1'h0;
        bus_req.data = ~d; // Released data no longer shows the written bit.
        repeat (3) @(posedge clk);
        #1;
    endtask

    // One serial read: hold the address four cycles, then take the return bit.
    // No emergency stop is ever raised here on an overload report.
    task automatic read_bit(input logic brd, input logic [5:0] pt, output logic b);
        @(posedge clk);
        #1;
        bus_req.board = brd;
        bus_req.point = pt;
        repeat (4) @(posedge clk);
        #1;
        b = serial_in_ff;
    endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
// Self-checking testbench of the serial I/O expansion path.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import io_expansion_pkg::*;
    logic        clk;
    logic        rstn;
    bus_req_t    bus_req;
    logic        serial_in_ff;
    logic        board_two_present;
    logic        bipolar_variant;
    logic [62:0] in1;
    logic [62:0] in2;
    logic [31:0] oc1;
    logic [31:0] oc2;
    logic [31:0] out1;
    logic [31:0] out2;
    logic [4:0]  neg1;
    logic [4:0]  neg2;
    logic        b;
    int          bad_count;
    int          comparisons;

    serial_io_expansion serial_io_expansion_inst (.clk(clk), .rstn(rstn), .bus_req(bus_req),
        .serial_in_ff(serial_in_ff), .board_two_present(board_two_present),
        .bipolar_variant(bipolar_variant), .board_one_inputs(in1), .board_two_inputs(in2),
        .board_one_overcurrent(oc1), .board_two_overcurrent(oc2), .board_one_out_ff(out1),
        .board_two_out_ff(out2), .board_one_neg_ff(neg1), .board_two_neg_ff(neg2));
    cpu_model cpu_model_inst (.clk(clk), .bus_req(bus_req), .serial_in_ff(serial_in_ff));

    // Prints the verdict and ends the run.
    task automatic tally_and_finish();
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits whole cycles and lands just after the edge.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Reads one point and compares the returned bit.
    task automatic rd(input logic brd, input logic [5:0] pt, input logic exp);
        cpu_model_inst.read_bit(brd, pt, b);
        check({31'h0, b}, {31'h0, exp});
    endtask

    // Spread of board one points, the last one included.
    task automatic test_read_one();
        for (int i = 2; i < 63; i += 12) begin
            rd(BOARD_ONE, 6'(i), in1[i]);
        end
    endtask

    // With two boards each board answers on its own return line.
    task automatic test_read_two();
        board_two_present = 1'h1;
        cyc(3);
        rd(BOARD_TWO, 6'h00, in2[0]);
        rd(BOARD_TWO, 6'h3E, in2[62]);
        rd(BOARD_ONE, 6'h3E, in1[62]);
        board_two_present = 1'h0;
        cyc(3);
        rd(BOARD_TWO, 6'h05, in1[5]);
    endtask

    // Serial writes build the parallel outputs; points above 31 write nothing.
    task automatic test_write();
        cpu_model_inst.write_bit(BOARD_ONE, 6'h00, 1'h1);
        cpu_model_inst.write_bit(BOARD_ONE, 6'h1E, 1'h1);
        cpu_model_inst.write_bit(BOARD_ONE, ESTOP_POINT, 1'h1);
        cpu_model_inst.write_bit(BOARD_TWO, 6'h05, 1'h1);
        cpu_model_inst.write_bit(BOARD_ONE, 6'h28, 1'h1);
        check(out1, 32'hC000_0001);
        check(out2, 32'h0000_0020);
        cpu_model_inst.write_bit(BOARD_ONE, 6'h00, 1'h0);
        check(out1, 32'hC000_0000);
    endtask

    // An overloaded output is off only while the overload lasts.
    task automatic test_overload();
        oc1 = 32'h4000_0000;
        cyc(4);
        check(out1, 32'h8000_0000);
        rd(BOARD_ONE, OVERLOAD_POINT, 1'h1);
        oc1 = 32'h0000_0000;
        cyc(4);
        check(out1, 32'hC000_0000);
        rd(BOARD_ONE, OVERLOAD_POINT, 1'h0);
        board_two_present = 1'h1;
        oc2 = 32'h0000_0020;
        cyc(4);
        check(out2, 32'h0000_0000);
        rd(BOARD_TWO, OVERLOAD_POINT, 1'h1);
        oc2 = 32'h0000_0000;
        board_two_present = 1'h0;
        cyc(4);
        check(out2, 32'h0000_0020);
    endtask

    // Bipolar channels 26 to 30 drive the negative side for a low bit.
    task automatic test_bipolar();
        bipolar_variant = 1'h1;
        cpu_model_inst.write_bit(BOARD_ONE, 6'h1A, 1'h0);
        check({27'h0, neg1}, 32'h0000_000F);
        check({27'h0, neg2}, 32'h0000_001F);
        cpu_model_inst.write_bit(BOARD_ONE, 6'h1A, 1'h1);
        check({27'h0, neg1}, 32'h0000_000E);
        check(out1, 32'hC400_0000);
    endtask

    // Free-running clock of 20 ns.
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Watchdog against a hung run.
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        bad_count = 0;
        comparisons = 0;
        rstn = 1'h0;
        board_two_present = 1'h0;
        bipolar_variant = 1'h0;
        in1 = 63'h1A5A_0F0F_3C3C_1234;
        in2 = ~63'h1A5A_0F0F_3C3C_1234;
        oc1 = 32'h0000_0000;
        oc2 = 32'h0000_0000;
        cyc(20);
        rstn = 1'h1;
        check(out1 | out2, 32'h0000_0000);
        check({22'h0, neg1, neg2}, 32'h0000_0000);
        test_read_one();
        test_read_two();
        test_write();
        test_overload();
        test_bipolar();
        tally_and_finish();
    end
endmodule
`default_nettype wire
